// File: hw/acc_pkg.sv
package acc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CFG_ONE = 12'h000;
    localparam logic [11:0] OFF_PWR_CTRL = 12'h004;
    localparam logic [11:0] OFF_CHAN_SEL = 12'h008;
    localparam logic [11:0] OFF_SW_START = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_RESULT_A = 12'h014;
    localparam logic [11:0] OFF_RESULT_B = 12'h018;
    localparam logic [11:0] OFF_INT_STAT = 12'h01C;
    localparam logic [11:0] OFF_INT_MASK = 12'h020;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_MODE_BIT = 0;
    localparam int CFG_CONT_BIT = 1;
    localparam int CFG_ACQ_LSB = 8;
    localparam int PWR_BGR0_BIT = 6;
    localparam int PWR_BGR1_BIT = 7;
    localparam int PWR_CONV_BIT = 5;
    localparam int SW_START_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int INT_SEQ_BIT = 0;
    localparam int INT_PAIR_BIT = 1;
    localparam int INT_REFUSE_BIT = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] ACQ_RST = 4'h0;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic [2:0] INT_MASK_RST = 3'h0;
    localparam logic [11:0] RESULT_RST = 12'h000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 40000000;
    localparam longint REF_SETTLE_MS = 5;
    localparam longint PWD_SETTLE_MS = 1;
    localparam int REF_SETTLE_CYC = int'((REF_SETTLE_MS * CLK_HZ) / 1000);
    localparam int PWD_SETTLE_CYC = int'((PWD_SETTLE_MS * CLK_HZ) / 1000);
    localparam int CONV_DIV = 4;
    // Sequencer timing is counted in half converter clocks; the interrupt lag in pclk cycles
    localparam logic [5:0] TRIG_DELAY_HALVES = 6'd5;
    localparam int RES_A_HALVES = 8;
    localparam int RES_B_HALVES = 10;
    localparam logic [5:0] SEQ_GAP_HALVES = 6'd2;
    localparam logic [5:0] SIM_GAP_HALVES = 6'd4;
    localparam int INT_LAG_CYC = 2;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_DELAY,
        ACC_HOLD,
        ACC_GAP
    } acc_state_t;

endpackage : acc_pkg

// File: hw/acc_half_div.sv
`timescale 1ns/1ps
module acc_half_div #(
    parameter int DIV = acc_pkg::CONV_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic half_tick
);
    import acc_pkg::*;

    localparam int HALF = (DIV / 2 < 1) ? 1 : DIV / 2;
    localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } acc_div_t;

    acc_div_t st_q;
    acc_div_t st_d;

    // ------------------------------------------------------------
    // Half-period enable of the converter clock
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == HALF_LAST) begin
            st_d.cnt = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign half_tick = st_q.tick;

endmodule : acc_half_div

// File: hw/acc_ctrl.sv
`timescale 1ns/1ps
module acc_ctrl #(
    parameter int REF_CYC = acc_pkg::REF_SETTLE_CYC,
    parameter int PWD_CYC = acc_pkg::PWD_SETTLE_CYC,
    parameter int DIV = acc_pkg::CONV_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_module_trigger,
    input wire logic external_conversion_start,
    input wire logic [11:0] conv_code_a,
    input wire logic [11:0] conv_code_b,
    output logic [1:0] bandgap_reference_power_bits,
    output logic converter_power_bit,
    output logic sample_hold,
    output logic [3:0] chan_sel,
    output logic pair_mode,
    output logic irq
);
    import acc_pkg::*;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic sampling_mode_select;
        logic cont;
        logic [3:0] acq;
        logic [1:0] bgr;
        logic pwr;
        logic [3:0] chan;
        logic [31:0] ref_cnt;
        logic [31:0] pwd_cnt;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic [11:0] code_a_s1;
        logic [11:0] code_a_s2;
        logic [11:0] code_b_s1;
        logic [11:0] code_b_s2;
        acc_state_t state;
        logic [5:0] cnt;
        logic sh;
        logic [RES_B_HALVES-1:0] pipe_v;
        logic [RES_B_HALVES-1:0] pipe_m;
        logic [RES_B_HALVES-1:0][11:0] pipe_a;
        logic [RES_B_HALVES-1:0][11:0] pipe_b;
        logic [11:0] res_a;
        logic [11:0] res_b;
        logic [INT_LAG_CYC-1:0][2:0] ev_lag;
        logic [2:0] int_stat;
        logic [2:0] int_mask;
        logic irq;
    } acc_state_reg_t;

    acc_state_reg_t st_q;
    acc_state_reg_t st_d;
    logic half_tick;

    acc_half_div #(
        .DIV(DIV)
    ) u_half_div (
        .pclk(pclk),
        .presetn(presetn),
        .half_tick(half_tick)
    );

    // ------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------
    always_comb begin
        logic acc_wr;
        logic acc_rd_phase;
        logic sw_start;
        logic start_req;
        logic ready;
        logic [31:0] rdata;
        logic rd_err;
        logic [5:0] hold_halves;
        logic [5:0] gap_halves;
        logic [2:0] ev_now;
        logic [2:0] ev_late;
        sw_start = 1'b0;
        rdata = 32'h0000_0000;
        rd_err = 1'b0;
        ev_now = 3'h0;
        st_d = st_q;

        // Write takes effect only on the edge that completes the access
        acc_wr = psel && penable && pwrite && st_q.pready;
        acc_rd_phase = psel && penable && !st_q.pready;

        // Two-flop synchronisers for pins
        st_d.ext_s1 = external_conversion_start;
        st_d.ext_s2 = st_q.ext_s1;
        st_d.ext_prev = st_q.ext_s2;
        st_d.code_a_s1 = conv_code_a;
        st_d.code_a_s2 = st_q.code_a_s1;
        st_d.code_b_s1 = conv_code_b;
        st_d.code_b_s2 = st_q.code_b_s1;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (acc_wr) begin
            unique case (paddr)
                OFF_CFG_ONE: begin
                    st_d.sampling_mode_select = pwdata[CFG_MODE_BIT];
                    st_d.cont = pwdata[CFG_CONT_BIT];
                    st_d.acq = pwdata[CFG_ACQ_LSB +: 4];
                end
                OFF_PWR_CTRL: begin
                    st_d.bgr = {pwdata[PWR_BGR1_BIT], pwdata[PWR_BGR0_BIT]};
                    st_d.pwr = pwdata[PWR_CONV_BIT];
                end
                OFF_CHAN_SEL: begin
                    st_d.chan = pwdata[3:0];
                end
                OFF_SW_START: begin
                    sw_start = pwdata[SW_START_BIT];
                end
                OFF_INT_MASK: begin
                    st_d.int_mask = pwdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Power settling timers
        // ------------------------------------------------------------
        // Timers restart whenever a bit drops, so a glitchy power-down is safe
        if (st_q.bgr != 2'b11) begin
            st_d.ref_cnt = 32'h0000_0000;
        end else if (st_q.ref_cnt != 32'(REF_CYC)) begin
            st_d.ref_cnt = st_q.ref_cnt + 32'h0000_0001;
        end
        if (!st_q.pwr) begin
            st_d.pwd_cnt = 32'h0000_0000;
        end else if (st_q.pwd_cnt != 32'(PWD_CYC)) begin
            st_d.pwd_cnt = st_q.pwd_cnt + 32'h0000_0001;
        end
        ready = st_q.pwr && (st_q.ref_cnt == 32'(REF_CYC)) &&
                (st_q.pwd_cnt == 32'(PWD_CYC));

        // ------------------------------------------------------------
        // Start sources
        // ------------------------------------------------------------
        start_req = pwm_module_trigger || sw_start ||
                    (st_q.ext_s2 && !st_q.ext_prev);
        hold_halves = 6'(({2'b00, st_q.acq} + 6'd1) << 1);
        gap_halves = st_q.sampling_mode_select ? SIM_GAP_HALVES : SEQ_GAP_HALVES;

        // ------------------------------------------------------------
        // Sequencer, in half converter clocks
        // ------------------------------------------------------------
        unique case (st_q.state)
            ACC_IDLE: begin
                if (start_req && ready) begin
                    st_d.state = ACC_DELAY;
                    st_d.cnt = TRIG_DELAY_HALVES - 6'd1;
                end else if (start_req) begin
                    ev_now[INT_REFUSE_BIT] = 1'b1;
                end
            end
            ACC_DELAY: begin
                if (half_tick) begin
                    if (st_q.cnt == 6'd0) begin
                        st_d.state = ACC_HOLD;
                        st_d.sh = 1'b1;
                        st_d.cnt = hold_halves - 6'd1;
                    end else begin
                        st_d.cnt = st_q.cnt - 6'd1;
                    end
                end
            end
            ACC_HOLD: begin
                if (half_tick) begin
                    if (st_q.cnt == 6'd0) begin
                        st_d.state = ACC_GAP;
                        st_d.sh = 1'b0;
                        st_d.cnt = gap_halves - 6'd1;
                    end else begin
                        st_d.cnt = st_q.cnt - 6'd1;
                    end
                end
            end
            ACC_GAP: begin
                if (half_tick) begin
                    if (st_q.cnt != 6'd0) begin
                        st_d.cnt = st_q.cnt - 6'd1;
                    end else if (st_q.cont) begin
                        st_d.state = ACC_HOLD;
                        st_d.sh = 1'b1;
                        st_d.cnt = hold_halves - 6'd1;
                    end else begin
                        st_d.state = ACC_IDLE;
                    end
                end
            end
        endcase
        // Dropping power aborts at once; in-flight results still drain
        if (!st_q.pwr) begin
            st_d.state = ACC_IDLE;
            st_d.sh = 1'b0;
        end

        // ------------------------------------------------------------
        // Conversion pipeline
        // ------------------------------------------------------------
        // Five converter-clock stages, each spanning two half-clocks; A is taken after four
        if (half_tick) begin
            st_d.pipe_v = {st_q.pipe_v[RES_B_HALVES-2:0],
                           st_q.state == ACC_HOLD && st_q.cnt == 6'd0 && st_q.pwr};
            st_d.pipe_m = {st_q.pipe_m[RES_B_HALVES-2:0], st_q.sampling_mode_select};
            st_d.pipe_a = {st_q.pipe_a[RES_B_HALVES-2:0], st_q.code_a_s2};
            st_d.pipe_b = {st_q.pipe_b[RES_B_HALVES-2:0], st_q.code_b_s2};
            if (st_q.pipe_v[RES_A_HALVES-1]) begin
                // Sequential picks the A or B mux by the channel's top bit
                if (!st_q.pipe_m[RES_A_HALVES-1] && st_q.chan[3]) begin
                    st_d.res_a = st_q.pipe_b[RES_A_HALVES-1];
                end else begin
                    st_d.res_a = st_q.pipe_a[RES_A_HALVES-1];
                end
                if (!st_q.pipe_m[RES_A_HALVES-1]) begin
                    ev_now[INT_SEQ_BIT] = 1'b1;
                end
            end
            if (st_q.pipe_v[RES_B_HALVES-1] && st_q.pipe_m[RES_B_HALVES-1]) begin
                st_d.res_b = st_q.pipe_b[RES_B_HALVES-1];
                ev_now[INT_PAIR_BIT] = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Interrupt flags
        // ------------------------------------------------------------
        st_d.ev_lag[0] = ev_now;
        for (int i = 1; i < INT_LAG_CYC; i++) begin
            st_d.ev_lag[i] = st_q.ev_lag[i-1];
        end
        ev_late = st_q.ev_lag[INT_LAG_CYC-1];
        if (acc_wr && paddr == OFF_INT_STAT) begin
            st_d.int_stat = st_q.int_stat & ~pwdata[2:0];
        end
        // A new event beats a clear in the same cycle
        st_d.int_stat = st_d.int_stat | ev_late;
        st_d.irq = |(st_d.int_stat & st_d.int_mask);

        // ------------------------------------------------------------
        // Read data, answered after one wait state
        // ------------------------------------------------------------
        unique case (paddr)
            OFF_CFG_ONE: begin
                rdata[CFG_MODE_BIT] = st_q.sampling_mode_select;
                rdata[CFG_CONT_BIT] = st_q.cont;
                rdata[CFG_ACQ_LSB +: 4] = st_q.acq;
            end
            OFF_PWR_CTRL: begin
                rdata[PWR_BGR1_BIT] = st_q.bgr[1];
                rdata[PWR_BGR0_BIT] = st_q.bgr[0];
                rdata[PWR_CONV_BIT] = st_q.pwr;
            end
            OFF_CHAN_SEL: begin
                rdata[3:0] = st_q.chan;
            end
            OFF_SW_START: begin
            end
            OFF_STATUS: begin
                rdata[STAT_BUSY_BIT] = (st_q.state != ACC_IDLE) || (|st_q.pipe_v);
                rdata[STAT_READY_BIT] = ready;
            end
            OFF_RESULT_A: begin
                rdata[11:0] = st_q.res_a;
            end
            OFF_RESULT_B: begin
                rdata[11:0] = st_q.res_b;
            end
            OFF_INT_STAT: begin
                rdata[2:0] = st_q.int_stat;
            end
            OFF_INT_MASK: begin
                rdata[2:0] = st_q.int_mask;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
        st_d.pready = acc_rd_phase;
        if (acc_rd_phase) begin
            st_d.prdata = pwrite ? 32'h0000_0000 : rdata;
            st_d.pslverr = rd_err;
        end else begin
            st_d.prdata = 32'h0000_0000;
            st_d.pslverr = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.state <= ACC_IDLE;
            st_q.acq <= ACQ_RST;
            st_q.chan <= CHAN_RST;
            st_q.int_mask <= INT_MASK_RST;
            st_q.res_a <= RESULT_RST;
            st_q.res_b <= RESULT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign bandgap_reference_power_bits = st_q.bgr;
    assign converter_power_bit = st_q.pwr;
    assign sample_hold = st_q.sh;
    assign chan_sel = st_q.chan;
    assign pair_mode = st_q.sampling_mode_select;
    assign irq = st_q.irq;

endmodule : acc_ctrl

// File: verification/acc_ctrl_properties.sv
`timescale 1ns/1ps
module acc_ctrl_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic converter_power_bit,
    input wire logic sample_hold,
    input wire logic [3:0] chan_sel,
    input wire logic pair_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Sample pulse shape, in pclk (one converter clock is four)
    // ------------------------------------------------------------
    sequence s_hold_min;
        sample_hold [*4];
    endsequence
    sequence s_gap_seq;
        !sample_hold [*4];
    endsequence
    sequence s_gap_pair;
        !sample_hold [*8];
    endsequence

    property p_hold_min;
        $rose(sample_hold) |-> s_hold_min;
    endproperty
    property p_hold_max;
        $rose(sample_hold) |-> ##[1:64] !sample_hold;
    endproperty
    property p_hold_powered;
        $rose(sample_hold) |-> converter_power_bit;
    endproperty
    property p_sel_steady;
        sample_hold && $past(sample_hold) |-> $stable({chan_sel, pair_mode});
    endproperty
    property p_seq_gap;
        $fell(sample_hold) && !pair_mode |-> s_gap_seq;
    endproperty
    property p_pair_gap;
        $fell(sample_hold) && pair_mode |-> s_gap_pair;
    endproperty

    // ------------------------------------------------------------
    // Register bus answer
    // ------------------------------------------------------------
    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    property p_ready_once;
        pready |=> !pready;
    endproperty
    property p_slverr_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    property p_rdata_idle;
        !pready |-> prdata == 32'h0000_0000;
    endproperty

    a_hold_min: assert property (p_hold_min)
        else $error("sample pulse shorter than one converter clock");
    a_hold_max: assert property (p_hold_max)
        else $error("sample pulse longer than sixteen converter clocks");
    a_hold_powered: assert property (p_hold_powered)
        else $error("sample pulse while converter unpowered");
    a_sel_steady: assert property (p_sel_steady)
        else $error("channel or mode moved during sample pulse");
    a_seq_gap: assert property (p_seq_gap)
        else $error("sequential gap too short");
    a_pair_gap: assert property (p_pair_gap)
        else $error("pair gap too short");
    a_apb_wait: assert property (p_apb_wait)
        else $error("bus answer missing after one wait state");
    a_ready_once: assert property (p_ready_once)
        else $error("ready held longer than one cycle");
    a_slverr_ready: assert property (p_slverr_ready)
        else $error("error flag outside an answer");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data driven outside an answer");

    c_pair: cover property ($fell(sample_hold) && pair_mode);
endmodule : acc_ctrl_properties

bind acc_ctrl acc_ctrl_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .converter_power_bit(converter_power_bit), .sample_hold(sample_hold),
    .chan_sel(chan_sel), .pair_mode(pair_mode));

// File: verification/acc_front_end.sv
`timescale 1ns/1ps
module acc_front_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_hold,
    input wire logic [3:0] chan_sel,
    output logic [11:0] conv_code_a,
    output logic [11:0] conv_code_b
);
    logic [3:0] cnt_q;
    logic hold_q;

    // Codes move just after each sample, so a stale capture shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            hold_q <= 1'b0;
        end else begin
            hold_q <= sample_hold;
            if (!sample_hold && hold_q) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // Both muxes share one count: a pair is taken together
    assign conv_code_a = {4'hA, cnt_q, 1'b0, chan_sel[2:0]};
    assign conv_code_b = {4'hB, cnt_q, 1'b0, chan_sel[2:0]};
endmodule : acc_front_end

// File: verification/adc_conversion_timing_control_bench.sv
`timescale 1ns/1ps
module adc_conversion_timing_control_bench;
    import acc_pkg::*;
    typedef struct packed {
        logic mode;
        logic [3:0] acq;
        logic [3:0] chan;
        logic [1:0] src;
    } acc_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pwm = 0, ext = 0;
    logic [11:0] paddr = 12'h000, code_a, code_b;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, pwr, hold, pmode, irq, er;
    logic [1:0] bgr;
    logic [3:0] chan;
    int n_fail = 0, check_count = 0, cyc = 0, t0, t1, t2, hits;
    // Mode, acquisition, channel, source (0 pwm, 1 software, 2 pin)
    acc_row_t rows [5] = '{'{1'b0, 4'd0, 4'd3, 2'd0}, '{1'b0, 4'd15, 4'd11, 2'd1},
        '{1'b1, 4'd2, 4'd5, 2'd2}, '{1'b1, 4'd0, 4'd7, 2'd0}, '{1'b0, 4'd5, 4'd8, 2'd2}};

    acc_ctrl #(.REF_CYC(20), .PWD_CYC(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_module_trigger(pwm),
        .external_conversion_start(ext), .conv_code_a(code_a), .conv_code_b(code_b),
        .bandgap_reference_power_bits(bgr), .converter_power_bit(pwr), .sample_hold(hold),
        .chan_sel(chan), .pair_mode(pmode), .irq(irq));
    acc_front_end FE (.pclk(pclk), .presetn(presetn), .sample_hold(hold), .chan_sel(chan),
        .conv_code_a(code_a), .conv_code_b(code_b));

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(rd, exp);
    endtask : rdchk
    task automatic wait_hold(input logic lvl);
        int n;
        n = 0;
        while (hold !== lvl && n < 300) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_hold
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            n++;
        end while (rd[STAT_READY_BIT] !== 1'b1 && n < 100);
        chk_bit(rd[STAT_READY_BIT], 1'b1);
    endtask : wait_ready
    task automatic fire(input logic [1:0] src);
        if (src == 2'd1) begin
            wr(OFF_SW_START, 32'h0000_0001);
        end else begin
            @(posedge pclk);
            pwm <= (src == 2'd0);
            ext <= (src == 2'd2);
            @(posedge pclk);
            pwm <= 1'b0;
            repeat (3) @(posedge pclk);
            ext <= 1'b0;
        end
    endtask : fire

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_bit(hold, 1'b0);
        chk_bit(irq, 1'b0);
        rdchk(OFF_CFG_ONE, 32'h0000_0000);
        rdchk(OFF_CHAN_SEL, 32'h0000_0000);
        rdchk(OFF_INT_MASK, 32'h0000_0000);
        rdchk(OFF_RESULT_A, 32'h0000_0000);
        rdchk(12'h0FC, 32'h0000_0000);
        chk_bit(er, 1'b1);
        wr(OFF_PWR_CTRL, 32'h0000_00C0);
        @(posedge pclk);
        chk_word({30'h0, bgr}, 32'h0000_0003);
        chk_bit(pwr, 1'b0);
        wr(OFF_PWR_CTRL, 32'h0000_00E0);
        wait_ready();
        chk_bit(pwr, 1'b1);
        foreach (rows[i]) begin
            wr(OFF_INT_MASK, rows[i].mode ? 32'h0000_0002 : 32'h0000_0001);
            wr(OFF_CFG_ONE, {20'h0, rows[i].acq, 7'h0, rows[i].mode});
            wr(OFF_CHAN_SEL, {28'h0, rows[i].chan});
            fire(rows[i].src);
            t0 = cyc;
            wait_hold(1'b1);
            t1 = cyc;
            chk_bit((t1 - t0) inside {[7:15]}, 1'b1);
            chk_bit(pmode, rows[i].mode);
            chk_word({28'h0, chan}, {28'h0, rows[i].chan});
            wait_hold(1'b0);
            t2 = cyc;
            chk_word(t2 - t1, 4 * (rows[i].acq + 1));
            while (irq !== 1'b1 && cyc - t2 < 60) @(posedge pclk);
            chk_word(cyc - t2, rows[i].mode ? 22 : 18);
            rdchk(OFF_RESULT_A, {20'h0, (rows[i].mode || !rows[i].chan[3]) ? 4'hA : 4'hB,
                4'(i), 1'b0, rows[i].chan[2:0]});
            if (rows[i].mode) begin
                rdchk(OFF_RESULT_B, {20'h0, 4'hB, 4'(i), 1'b0, rows[i].chan[2:0]});
            end
            wr(OFF_INT_STAT, 32'h0000_0007);
            rdchk(OFF_INT_STAT, 32'h0000_0000);
            chk_bit(irq, 1'b0);
        end
        for (int m = 0; m < 2; m++) begin
            wr(OFF_PWR_CTRL, 32'h0000_0000);
            wr(OFF_INT_STAT, 32'h0000_0007);
            wr(OFF_INT_MASK, 32'h0000_0000);
            wr(OFF_PWR_CTRL, 32'h0000_00E0);
            wr(OFF_SW_START, 32'h0000_0001);
            rdchk(OFF_INT_STAT, 32'h0000_0004);
            chk_bit(hold, 1'b0);
            chk_bit(irq, 1'b0);
            wr(OFF_INT_MASK, 32'h0000_0004);
            rdchk(OFF_INT_STAT, 32'h0000_0004);
            chk_bit(irq, 1'b1);
            wr(OFF_INT_STAT, 32'h0000_0007);
            rdchk(OFF_INT_STAT, 32'h0000_0000);
            chk_bit(irq, 1'b0);
            wait_ready();
            wr(OFF_CFG_ONE, {20'h0, 4'h1, 6'h0, 1'b1, m[0]});
            fire(2'd0);
            wait_hold(1'b1);
            t1 = cyc;
            wait_hold(1'b0);
            wait_hold(1'b1);
            chk_word(cyc - t1, m ? 16 : 12);
            wr(OFF_PWR_CTRL, 32'h0000_00C0);
            fire(2'd0);
            repeat (8) @(posedge pclk);
            chk_bit(pwr, 1'b0);
            hits = 0;
            repeat (60) begin
                @(posedge pclk);
                if (hold === 1'b1) hits++;
            end
            chk_word(hits, 0);
        end
        test_done();
    end
endmodule : adc_conversion_timing_control_bench
